// *** shared/dpbio_pkg.sv ***
// constants, encodings and carrier types of the dual bidirectional io port block
`default_nettype none
package dpbio_pkg;
    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int unsigned PORT_W     = 8;   // lines per port
    localparam int unsigned LINES_W    = 16;  // lines over both ports
    localparam int unsigned ADDR_W     = 4;   // register address width
    localparam int unsigned IRQ_W      = 3;   // sticky event bits

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [3:0] OFS_FIRST_DATA  = 4'h0; // first_port latch / read view
    localparam logic [3:0] OFS_FIRST_DIR   = 4'h1; // first_port_direction
    localparam logic [3:0] OFS_SECOND_DATA = 4'h2; // second_port latch / read view
    localparam logic [3:0] OFS_SECOND_DIR  = 4'h3; // second_port_direction
    localparam logic [3:0] OFS_BIT_CMD     = 4'h4; // bit set / clear / complement
    localparam logic [3:0] OFS_ACC         = 4'h5; // complement-to-accumulator result
    localparam logic [3:0] OFS_IRQ_STAT    = 4'h6; // sticky events, write one to clear
    localparam logic [3:0] OFS_IRQ_MASK    = 4'h7; // event enables
    localparam logic [3:0] OFS_WAKE_EN     = 4'h8; // wake option per first_port bit
    localparam logic [3:0] OFS_PULL_FIRST  = 4'h9; // pull-high option, first_port
    localparam logic [3:0] OFS_PULL_SECOND = 4'ha; // pull-high option, second_port
    localparam logic [3:0] OFS_TRIG        = 4'hb; // trigger modes of both ext irqs
    localparam logic [3:0] OFS_SENSOR      = 4'hc; // sensor line selection

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int unsigned CMD_IDX_LSB    = 0;  // bit index, three bits
    localparam int unsigned CMD_PORT_BIT   = 3;  // 0 first_port, 1 second_port
    localparam int unsigned CMD_OP_LSB     = 4;  // operation, two bits
    localparam int unsigned TRIG0_LSB      = 0;  // ext irq zero mode
    localparam int unsigned TRIG1_LSB      = 2;  // ext irq one mode
    localparam int unsigned SENS_LOW_BIT   = 0;  // sensor_lines_low on bits 0..3
    localparam int unsigned SENS_HIGH_BIT  = 1;  // sensor_lines_high on bits 4..7
    localparam int unsigned IRQ_EXT0_BIT   = 0;  // ext irq zero event
    localparam int unsigned IRQ_EXT1_BIT   = 1;  // ext irq one event
    localparam int unsigned IRQ_WAKE_BIT   = 2;  // first_port wake event
    localparam int unsigned PIN_EXT0       = 0;  // ext_irq_zero_pin line
    localparam int unsigned PIN_EXT1       = 1;  // ext_irq_one_pin line
    localparam int unsigned PIN_TIMER      = 2;  // timer_input_pin line

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_DIR    = 8'hff; // every line an input
    localparam logic [7:0] RST_LATCH  = 8'h00;
    localparam logic [7:0] RST_OPTION = 8'h00; // no pull-high, no wake
    localparam logic [3:0] RST_TRIG   = 4'h0;  // both ext irqs disabled
    localparam logic [1:0] RST_SENSOR = 2'h0;  // all lines plain io
    localparam logic [2:0] RST_IRQ    = 3'h0;

    // ----------------------------------------------------------------
    // encodings and carriers
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        TRIG_OFF  = 2'b00,
        TRIG_RISE = 2'b01,
        TRIG_FALL = 2'b10,
        TRIG_BOTH = 2'b11
    } dpbio_trig_e;

    typedef enum logic [1:0] {
        BITOP_SET  = 2'b00, // set one latch bit
        BITOP_CLR  = 2'b01, // clear one latch bit
        BITOP_CPL  = 2'b10, // complement port into latch
        BITOP_CPLA = 2'b11  // complement port into accumulator
    } dpbio_bitop_e;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } dpbio_bus_req_s;
endpackage
`default_nettype wire

// *** core/dpbio_top.sv ***
// dual eight-bit bidirectional io port with options, shared pins and events
//
// Summary of operation
// - sixteen bidirectional lines in two eight-bit ports
// - input-line reads sample pad level, never latched
// - output latch holds until software rewrites it
// - per-line direction bit, one means input
// - read gives pad for inputs, latch for outputs
// - output lines driven push-pull high and low
// - reset makes every line an input
// - single latch bits settable and clearable alone
// - bit operations read port, modify, write back
// - first-port lines wake device, per-bit option
// - per-line pull-high option, else input floats
// - first-port bits 0-2 feed irqs and timer
// - sensor-selected nibbles drop data and direction bits
// - ext irq trigger: off, rise, fall, both
//
// The address map and the address-and-strobe port were chosen for this implementation.
`default_nettype none
module dpbio_top (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire dpbio_pkg::dpbio_bus_req_s bus_req,
    output logic [7:0]                    rdata_ff,
    input  wire logic [15:0]              pad_in,
    output logic [15:0]                   pad_out_ff,
    output logic [15:0]                   pad_oe_ff,
    output logic [15:0]                   pull_en_ff,
    output logic                          timer_input_pin_ff,
    output logic                          sensor_lines_low_ff,
    output logic                          sensor_lines_high_ff,
    output logic                          wake_ff,
    output logic                          irq_ff
);
    import dpbio_pkg::*;

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------
    // implemented first_port bits for a sensor selection
    function automatic logic [7:0] impl_of(input logic [1:0] sens);
        impl_of = {{4{~sens[SENS_HIGH_BIT]}}, {4{~sens[SENS_LOW_BIT]}}};
    endfunction

    // pad for input bits, latch for output bits
    function automatic logic [7:0] view_of(input logic [7:0] latch,
                                           input logic [7:0] dir,
                                           input logic [7:0] pad);
        view_of = (dir & pad) | (~dir & latch);
    endfunction

    // trigger detection for one ext irq line
    function automatic logic trig_hit(input logic [1:0] mode,
                                      input logic       cur,
                                      input logic       prev);
        case (dpbio_trig_e'(mode))
            TRIG_RISE: trig_hit = cur & ~prev;
            TRIG_FALL: trig_hit = ~cur & prev;
            TRIG_BOTH: trig_hit = cur ^ prev;
            default:   trig_hit = 1'b0;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // reset release and pad synchronisers
    // ----------------------------------------------------------------
    logic        rst_meta_ff;  // first reset stage
    logic        rst_int_n;    // released reset copy
    logic [15:0] pad_meta_ff;  // first pad stage
    logic [15:0] pad_sync_ff;  // pad level seen by logic

    // reset released through two flip-flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_int_n   <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_int_n   <= rst_meta_ff;
        end
    end

    // pads cross in through two flip-flops
    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            pad_meta_ff <= 16'h0000;
            pad_sync_ff <= 16'h0000;
        end else begin
            pad_meta_ff <= pad_in;
            pad_sync_ff <= pad_meta_ff;
        end
    end

    // ----------------------------------------------------------------
    // configuration and port registers
    // ----------------------------------------------------------------
    logic [7:0] latch_a_ff;  // first_port output latch
    logic [7:0] latch_b_ff;  // second_port output latch
    logic [7:0] dir_a_ff;    // first_port_direction
    logic [7:0] dir_b_ff;    // second_port_direction
    logic [7:0] pull_a_ff;   // pull-high option, first_port
    logic [7:0] pull_b_ff;   // pull-high option, second_port
    logic [7:0] wake_en_ff;  // wake option, first_port
    logic [3:0] trig_ff;     // ext irq modes
    logic [1:0] sensor_ff;   // sensor nibble selection
    logic [7:0] acc_ff;      // complement-to-accumulator result
    logic [7:0] impl_a;      // implemented first_port bits
    logic [7:0] pad_a;       // first_port pad level
    logic [7:0] pad_b;       // second_port pad level
    logic [7:0] view_a;      // first_port read view
    logic [7:0] view_b;      // second_port read view
    logic       wr_data_a;   // write to first_port latch
    logic       wr_data_b;   // write to second_port latch
    logic       wr_cmd;      // bit operation request
    logic       cmd_port;    // bit operation targets second_port
    logic [2:0] cmd_idx;     // bit operation index
    dpbio_bitop_e cmd_op;    // bit operation kind
    logic [7:0] rmw_src;     // port read for the operation
    logic [7:0] rmw_res;     // modified byte

    assign impl_a    = impl_of(sensor_ff);
    assign pad_a     = pad_sync_ff[7:0];
    assign pad_b     = pad_sync_ff[15:8];
    // unlatched reads of pad, unimplemented bits forced to zero
    assign view_a    = view_of(latch_a_ff, dir_a_ff, pad_a) & impl_a;
    assign view_b    = view_of(latch_b_ff, dir_b_ff, pad_b);
    assign wr_data_a = bus_req.wr && (bus_req.addr == OFS_FIRST_DATA);
    assign wr_data_b = bus_req.wr && (bus_req.addr == OFS_SECOND_DATA);
    assign wr_cmd    = bus_req.wr && (bus_req.addr == OFS_BIT_CMD);
    assign cmd_port  = bus_req.wdata[CMD_PORT_BIT];
    assign cmd_idx   = bus_req.wdata[CMD_IDX_LSB +: 3];
    assign cmd_op    = dpbio_bitop_e'(bus_req.wdata[CMD_OP_LSB +: 2]);

    // read-modify-write of a whole port for the bit operations
    always_comb begin
        rmw_src = cmd_port ? view_b : view_a;
        rmw_res = rmw_src;
        case (cmd_op)
            BITOP_SET:  rmw_res = rmw_src | (8'h01 << cmd_idx);
            BITOP_CLR:  rmw_res = rmw_src & ~(8'h01 << cmd_idx);
            BITOP_CPL:  rmw_res = ~rmw_src;
            BITOP_CPLA: rmw_res = ~rmw_src;
            default:    rmw_res = rmw_src;
        endcase
    end

    // output latches change only on a data write or a bit operation
    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            latch_a_ff <= RST_LATCH;
            latch_b_ff <= RST_LATCH;
        end else if (wr_data_a) begin
            // sensor-owned bits keep their value, writes ignored
            latch_a_ff <= (bus_req.wdata & impl_a) | (latch_a_ff & ~impl_a);
        end else if (wr_data_b) begin
            latch_b_ff <= bus_req.wdata;
        end else if (wr_cmd && (cmd_op != BITOP_CPLA)) begin
            // result written back to the selected latch
            if (cmd_port) begin
                latch_b_ff <= rmw_res;
            end else begin
                latch_a_ff <= (rmw_res & impl_a) | (latch_a_ff & ~impl_a);
            end
        end
    end

    // accumulator result of complement-to-accumulator
    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            acc_ff <= RST_LATCH;
        end else if (wr_cmd && (cmd_op == BITOP_CPLA)) begin
            acc_ff <= rmw_res;
        end
    end

    // direction bits, one selects input, changeable any time
    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            dir_a_ff <= RST_DIR;
            dir_b_ff <= RST_DIR;
        end else if (bus_req.wr && (bus_req.addr == OFS_FIRST_DIR)) begin
            dir_a_ff <= (bus_req.wdata & impl_a) | (dir_a_ff & ~impl_a);
        end else if (bus_req.wr && (bus_req.addr == OFS_SECOND_DIR)) begin
            dir_b_ff <= bus_req.wdata;
        end
    end

    // option registers: pull-high, wake, triggers, sensor selection
    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            pull_a_ff  <= RST_OPTION;
            pull_b_ff  <= RST_OPTION;
            wake_en_ff <= RST_OPTION;
            trig_ff    <= RST_TRIG;
            sensor_ff  <= RST_SENSOR;
        end else if (bus_req.wr) begin
            case (bus_req.addr)
                OFS_PULL_FIRST:  pull_a_ff  <= bus_req.wdata;
                OFS_PULL_SECOND: pull_b_ff  <= bus_req.wdata;
                OFS_WAKE_EN:     wake_en_ff <= bus_req.wdata;
                OFS_TRIG:        trig_ff    <= bus_req.wdata[3:0];
                OFS_SENSOR:      sensor_ff  <= bus_req.wdata[1:0];
                default:         ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // shared pin functions and events
    // ----------------------------------------------------------------
    logic [1:0]     ext_prev_ff;  // previous ext irq pin levels
    logic [7:0]     wake_prev_ff; // previous first_port pad levels
    logic [IRQ_W-1:0] irq_stat_ff; // sticky events
    logic [IRQ_W-1:0] irq_mask_ff; // event enables
    logic [IRQ_W-1:0] irq_set;     // events this cycle
    logic [IRQ_W-1:0] irq_clr;     // write-one-to-clear bits
    logic [7:0]     wake_lines;    // lines able to wake

    assign wake_lines = wake_en_ff & dir_a_ff & impl_a;
    assign irq_set[IRQ_EXT0_BIT] = impl_a[PIN_EXT0] &&
        trig_hit(trig_ff[TRIG0_LSB +: 2], pad_a[PIN_EXT0], ext_prev_ff[0]);
    assign irq_set[IRQ_EXT1_BIT] = impl_a[PIN_EXT1] &&
        trig_hit(trig_ff[TRIG1_LSB +: 2], pad_a[PIN_EXT1], ext_prev_ff[1]);
    assign irq_set[IRQ_WAKE_BIT] = |((pad_a ^ wake_prev_ff) & wake_lines);
    assign irq_clr = (bus_req.wr && (bus_req.addr == OFS_IRQ_STAT)) ?
                     bus_req.wdata[IRQ_W-1:0] : RST_IRQ;

    // history for edge and change detection on synchronised pads
    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            ext_prev_ff  <= 2'h0;
            wake_prev_ff <= RST_OPTION;
        end else begin
            ext_prev_ff  <= {pad_a[PIN_EXT1], pad_a[PIN_EXT0]};
            wake_prev_ff <= pad_a;
        end
    end

    // sticky status, a new event wins over a clear
    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            irq_stat_ff <= RST_IRQ;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
        end
    end

    // interrupt mask
    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            irq_mask_ff <= RST_IRQ;
        end else if (bus_req.wr && (bus_req.addr == OFS_IRQ_MASK)) begin
            irq_mask_ff <= bus_req.wdata[IRQ_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    // pad drivers: push-pull where direction is zero and bit implemented
    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            pad_out_ff <= 16'h0000;
            pad_oe_ff  <= 16'h0000;
            pull_en_ff <= 16'h0000;
        end else begin
            pad_out_ff <= {latch_b_ff, latch_a_ff & impl_a};
            pad_oe_ff  <= {~dir_b_ff, ~dir_a_ff & impl_a};
            pull_en_ff <= {pull_b_ff, pull_a_ff & impl_a};
        end
    end

    // shared functions, wake and interrupt lines
    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            timer_input_pin_ff   <= 1'b0;
            sensor_lines_low_ff  <= 1'b0;
            sensor_lines_high_ff <= 1'b0;
            wake_ff              <= 1'b0;
            irq_ff               <= 1'b0;
        end else begin
            timer_input_pin_ff   <= pad_a[PIN_TIMER] & impl_a[PIN_TIMER];
            sensor_lines_low_ff  <= sensor_ff[SENS_LOW_BIT];
            sensor_lines_high_ff <= sensor_ff[SENS_HIGH_BIT];
            wake_ff              <= irq_stat_ff[IRQ_WAKE_BIT];
            irq_ff               <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    // read data stand one cycle after the strobe, zero otherwise
    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            rdata_ff <= 8'h00;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                OFS_FIRST_DATA:  rdata_ff <= view_a;
                OFS_FIRST_DIR:   rdata_ff <= dir_a_ff & impl_a;
                OFS_SECOND_DATA: rdata_ff <= view_b;
                OFS_SECOND_DIR:  rdata_ff <= dir_b_ff;
                OFS_ACC:         rdata_ff <= acc_ff;
                OFS_IRQ_STAT:    rdata_ff <= {5'h00, irq_stat_ff};
                OFS_IRQ_MASK:    rdata_ff <= {5'h00, irq_mask_ff};
                OFS_WAKE_EN:     rdata_ff <= wake_en_ff;
                OFS_PULL_FIRST:  rdata_ff <= pull_a_ff;
                OFS_PULL_SECOND: rdata_ff <= pull_b_ff;
                OFS_TRIG:        rdata_ff <= {4'h0, trig_ff};
                OFS_SENSOR:      rdata_ff <= {6'h00, sensor_ff};
                default:         rdata_ff <= 8'h00;
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence seq_rd_first;
        bus_req.rd && (bus_req.addr == OFS_FIRST_DATA);
    endsequence

    sequence seq_set_first;
        wr_cmd && !cmd_port && (cmd_op == BITOP_SET) && impl_a[cmd_idx];
    endsequence

    sequence seq_no_first_write;
        !wr_data_a && !(wr_cmd && !cmd_port && (cmd_op != BITOP_CPLA));
    endsequence

    chk_reset_inputs: assert property (@(posedge clk)
        $rose(rst_int_n) |-> (dir_a_ff == RST_DIR) && (dir_b_ff == RST_DIR)
                             && (pad_oe_ff == 16'h0000))
        else $error("lines not all inputs after reset");

    chk_read_view: assert property (@(posedge clk) disable iff (!rst_int_n)
        seq_rd_first |=> rdata_ff == ($past(dir_a_ff & pad_a | ~dir_a_ff & latch_a_ff)
                                      & $past(impl_a)))
        else $error("first port read view wrong");

    chk_rdata_idle: assert property (@(posedge clk) disable iff (!rst_int_n)
        !bus_req.rd |=> rdata_ff == 8'h00)
        else $error("read data outside read cycle");

    chk_latch_hold: assert property (@(posedge clk) disable iff (!rst_int_n)
        seq_no_first_write |=> $stable(latch_a_ff))
        else $error("latch changed without write");

    chk_bit_set: assert property (@(posedge clk) disable iff (!rst_int_n)
        seq_set_first |=> latch_a_ff[$past(cmd_idx)] == 1'b1)
        else $error("bit set did not reach latch");

    chk_unimpl_zero: assert property (@(posedge clk) disable iff (!rst_int_n)
        seq_rd_first ##0 sensor_ff[SENS_LOW_BIT] |=> rdata_ff[3:0] == 4'h0)
        else $error("sensor nibble read nonzero");

    chk_oe_push_pull: assert property (@(posedge clk) disable iff (!rst_int_n)
        ##1 pad_oe_ff[15:8] == ~$past(dir_b_ff))
        else $error("drive enable not from direction");

    chk_ext_rise: assert property (@(posedge clk) disable iff (!rst_int_n)
        (trig_ff[TRIG0_LSB +: 2] == TRIG_RISE) && impl_a[PIN_EXT0] && pad_a[PIN_EXT0]
        && !ext_prev_ff[0] |=> irq_stat_ff[IRQ_EXT0_BIT] ##1 irq_stat_ff[IRQ_EXT0_BIT]
        || $past(irq_clr[IRQ_EXT0_BIT]))
        else $error("rising edge event lost");

    chk_irq_level: assert property (@(posedge clk) disable iff (!rst_int_n)
        ##1 irq_ff == $past(|(irq_stat_ff & irq_mask_ff)))
        else $error("interrupt output mismatch");
endmodule
`default_nettype wire

// *** dv/dpbio_pins.sv ***
// behavioural model of the pads and switches beside the io port block
`default_nettype none
module dpbio_pins (
    input  wire logic        clk,
    input  wire logic [15:0] drv_val,
    input  wire logic [15:0] drv_oe,
    input  wire logic [15:0] pull_en,
    input  wire logic [15:0] ext_val,
    input  wire logic [15:0] ext_drv,
    output logic [15:0]      pad
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] last_ff; // level of each pad one cycle ago
    // ------------------------------------------------------------
    // pad resolution: block drive, then switch, then pull, else toggling each cycle like a floating line
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        last_ff <= pad;
    end
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (drv_oe[i]) begin
                pad[i] = drv_val[i];
            end else if (ext_drv[i]) begin
                pad[i] = ext_val[i];
            end else if (pull_en[i]) begin
                pad[i] = 1'b1;
            end else begin
                pad[i] = ~last_ff[i];
            end
        end
    end
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// self-checking testbench of the dual io port block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import dpbio_pkg::*;
    logic           clk, rst_n, tmr, s_lo, s_hi, wake_ff, irq_ff;
    dpbio_bus_req_s req;
    logic [7:0]     rdata_ff;
    logic [15:0]    pad, pad_out_ff, pad_oe_ff, pull_en_ff, ext_val, ext_drv;
    int             miscompares, check_count;
    dpbio_top i_dpbio_top (.clk(clk), .rst_n(rst_n), .bus_req(req), .rdata_ff(rdata_ff),
        .pad_in(pad), .pad_out_ff(pad_out_ff), .pad_oe_ff(pad_oe_ff),
        .pull_en_ff(pull_en_ff), .timer_input_pin_ff(tmr), .sensor_lines_low_ff(s_lo),
        .sensor_lines_high_ff(s_hi), .wake_ff(wake_ff), .irq_ff(irq_ff));
    dpbio_pins i_dpbio_pins (.clk(clk), .drv_val(pad_out_ff), .drv_oe(pad_oe_ff),
        .pull_en(pull_en_ff), .ext_val(ext_val), .ext_drv(ext_drv), .pad(pad));
    // compare one value and count it
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one-cycle write strobe, then one idle cycle
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
        @(posedge clk);
    endtask
    // one-cycle read strobe; data stand in the next cycle and are taken at its closing edge
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        @(posedge clk);
        chk({8'h00, rdata_ff}, {8'h00, exp});
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #(50 * 3000);
        miscompares++;
        results();
    end
    initial begin
        rst_n = 1'b0;
        req = '0;
        ext_val = 16'h3c5a;
        ext_drv = 16'hffff;
        cyc(16);
        rst_n <= 1'b1;
        cyc(5);
        rd(OFS_FIRST_DIR, 8'hff);
        rd(OFS_SECOND_DIR, 8'hff);
        rd(OFS_FIRST_DATA, 8'h5a);
        chk(pad_oe_ff, 16'h0000);
        $display("reset test done");
        wr(OFS_FIRST_DIR, 8'h0f);
        wr(OFS_FIRST_DATA, 8'ha5);
        cyc(3);
        rd(OFS_FIRST_DATA, 8'haa);
        chk(pad_oe_ff, 16'h00f0);
        chk({8'h00, pad_out_ff[7:0]}, 16'h00a5);
        $display("direction test done");
        wr(OFS_SECOND_DIR, 8'h00);
        wr(OFS_BIT_CMD, 8'h0f);
        wr(OFS_BIT_CMD, 8'h1f);
        wr(OFS_BIT_CMD, 8'h0b);
        cyc(2);
        chk({8'h00, pad_out_ff[15:8]}, 16'h0008);
        wr(OFS_BIT_CMD, 8'h30);
        rd(OFS_ACC, 8'h55);
        wr(OFS_BIT_CMD, 8'h20);
        cyc(3);
        rd(OFS_FIRST_DATA, 8'h5a);
        $display("bit operation test done");
        wr(OFS_FIRST_DIR, 8'hff);
        wr(OFS_IRQ_MASK, 8'h01);
        for (int m = 0; m < 4; m++) begin
            wr(OFS_TRIG, 8'(m));
            ext_val[0] <= 1'b1;
            cyc(6);
            chk({15'h0, irq_ff}, {15'h0, m[0]});
            wr(OFS_IRQ_STAT, 8'h07);
            ext_val[0] <= 1'b0;
            cyc(6);
            rd(OFS_IRQ_STAT, {7'h00, m[1]});
            wr(OFS_IRQ_STAT, 8'h07);
            cyc(2);
            chk({15'h0, irq_ff}, 16'h0000);
        end
        $display("trigger test done");
        // wake on bit 3 change, timer input follows bit 2
        wr(OFS_WAKE_EN, 8'h08);
        ext_val[3:2] <= 2'b01;
        cyc(5);
        chk({15'h0, tmr}, 16'h0001);
        chk({15'h0, wake_ff}, 16'h0001);
        rd(OFS_IRQ_STAT, 8'h04);
        chk({15'h0, irq_ff}, 16'h0000);
        wr(OFS_IRQ_STAT, 8'h04);
        $display("shared pin test done");
        wr(OFS_SENSOR, 8'h01);
        wr(OFS_FIRST_DIR, 8'h3c);
        rd(OFS_FIRST_DIR, 8'h30);
        wr(OFS_PULL_FIRST, 8'hff);
        cyc(2);
        chk({8'h00, pull_en_ff[7:0]}, 16'h00f0);
        chk({15'h0, s_lo}, 16'h0001);
        chk({15'h0, s_hi}, 16'h0000);
        rd(4'hd, 8'h00);
        $display("sensor test done");
        results();
    end
endmodule
`default_nettype wire
